// *** design/sda_pkg.sv ***
// Purpose: Shared constants for the serial audio link, both ends
// Assumes: One 125 MHz system clock on the controller side
// Notes:   Static control lines travel as one vector, positions below
package sda_pkg;
    // ------------------------------------------------------------
    // Sample and framing
    // ------------------------------------------------------------
    localparam int SMP_W = 24;
    localparam int MIN_W = 16;
    localparam int CNT_W = 5;
    localparam int FRM_W = 9;
    localparam logic [1:0] FMT_I2S = 2'h0;
    localparam logic [1:0] FMT_LJ = 2'h1;
    localparam logic [1:0] FMT_RJ16 = 2'h2;
    localparam logic [1:0] FMT_RJ24 = 2'h3;
    localparam logic [4:0] OFF_I2S = 5'h01;
    localparam logic [4:0] OFF_RJ16 = 5'h10;
    localparam logic [4:0] OFF_RJ24 = 5'h08;
    localparam logic [4:0] LEN_MIN = 5'h10;
    localparam logic [4:0] LEN_MAX = 5'h18;
    // ------------------------------------------------------------
    // Static control vector
    // ------------------------------------------------------------
    localparam int STAT_W = 9;
    localparam int S_FMT = 0;
    localparam int S_GAIN = 2;
    localparam int S_DAC = 4;
    localparam int S_MIC = 5;
    localparam int S_MONO = 6;
    localparam int S_MUTE_L = 7;
    localparam int S_MUTE_R = 8;
    // ------------------------------------------------------------
    // Controller registers
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CTRL_W = 16;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_LEFT = 4'h1;
    localparam logic [ADDR_W-1:0] REG_RIGHT = 4'h2;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h3;
    localparam int C_WLEN = 2;
    localparam int C_STAT = 7;
    localparam int C_DRIVE = 14;
    localparam int C_RUN = 15;
    localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0060;
    // ------------------------------------------------------------
    // Clock plan
    // ------------------------------------------------------------
    localparam longint MCLK_HZ = 125000000;
    localparam longint OS_RATIO = 256;
    localparam longint FS_MIN_HZ = 32000;
    localparam longint FS_MAX_HZ = 48000;
    localparam longint OS_STEP = OS_RATIO * FS_MAX_HZ * 2;
    localparam int OS_HALF_DEF = int'((MCLK_HZ + OS_STEP - 1) / OS_STEP);
    localparam int PH_W = 8;
endpackage

// *** design/sda_link_if.sv ***
// Purpose: Four-line serial audio link plus static control lines
// Assumes: Controller drives every line; the card only listens
// Notes:   Released static lines read low, as the pull-downs make them
`timescale 1ns/1ns
interface sda_link_if;
    import sda_pkg::*;
    logic lrclk;
    logic sdata;
    logic bclk;
    logic osclk;
    logic [STAT_W-1:0] ctl_val;
    logic ctl_oe_n;
    logic [STAT_W-1:0] ctl_line;
    // ------------------------------------------------------------
    // Pull-downs on all static lines
    // ------------------------------------------------------------
    assign ctl_line = ctl_oe_n ? '0 : ctl_val;
    modport ctrl (output lrclk, sdata, bclk, osclk, ctl_val, ctl_oe_n);
    modport dev (input lrclk, sdata, bclk, osclk, ctl_line);
endinterface

// *** design/sda_card.sv ***
// Purpose: Card end: serial audio receiver and static line decoding
// Assumes: Clocked by the link bit clock; reset held while it runs
// Notes:   Samples leave MSB aligned in 24 bits, one strobe per pair
//
// Notes on behaviour
// RULE1: Link is channel select, data, bit, oversample clocks
// RULE2: Oversampling clock runs at 256 times sample rate
// RULE3: Words of 16 to 24 bits accepted
// RULE4: Sample rates 32 to 48 kHz supported
// RULE5: Two format lines, static while streaming
// RULE6: Four framings: RJ16, RJ24, LJ, I2S
// RULE7: Data and channel select taken on rising edge
// RULE8: Low standby line puts converter in standby
// RULE9: Undriven converter standby means standby
// RULE10: Undriven format lines select format zero
// RULE11: Controller drives gain and two mute lines
// RULE12: Undriven microphone standby keeps preamp off
// RULE13: Two gain lines, minimum gain when undriven
// RULE14: Mono amplifier off unless driven high
// RULE15: Channel select routes words left or right
`timescale 1ns/1ns
module sda_card (
    // Link
    sda_link_if.dev LNK,
    // Reset, on the bit clock
    input wire logic RESET_N,
    // Samples
    output logic [sda_pkg::SMP_W-1:0] LEFT_SAMPLE,
    output logic [sda_pkg::SMP_W-1:0] RIGHT_SAMPLE,
    output logic SAMPLE_STROBE,
    // Static state
    output logic [1:0] FORMAT,
    output logic DAC_ACTIVE,
    output logic MIC_ACTIVE,
    output logic MONO_AMP_ON,
    output logic [1:0] AMP_GAIN,
    output logic MUTE_LEFT,
    output logic MUTE_RIGHT
);
    import sda_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [STAT_W-1:0] sync1;
        logic [STAT_W-1:0] sync2;
        logic lr;
        logic [SMP_W-1:0] shreg;
        logic [CNT_W-1:0] cnt;
        logic [SMP_W-1:0] left;
        logic [SMP_W-1:0] out_l;
        logic [SMP_W-1:0] out_r;
        logic strobe;
    } sda_card_t;

    sda_card_t q;
    sda_card_t d;
    logic lr_edge;
    logic left_ch;
    logic dac_on;
    logic [1:0] fmt;
    logic [SMP_W-1:0] word;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Left-justified words of any length end up MSB aligned
    function automatic logic [SMP_W-1:0] sda_align(input logic [SMP_W-1:0] w,
                                                   input logic [CNT_W-1:0] n);
        sda_align = w << (CNT_W'(SMP_W) - n);
    endfunction

    // Right-justified words are the last bits before the edge
    function automatic logic [SMP_W-1:0] sda_rj(input logic [SMP_W-1:0] w,
                                                input logic [1:0] f);
        if (f == FMT_RJ16) begin
            sda_rj = {w[MIN_W-1:0], {(SMP_W-MIN_W){1'b0}}};
        end else begin
            sda_rj = w;
        end
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        lr_edge = 1'b0;
        left_ch = 1'b0;
        word = '0;
        // Pins from the other board pass two flops before use
        d.sync1 = LNK.ctl_line;
        d.sync2 = q.sync1;
        // Released lines read zero: format zero, standby, min gain
        fmt = q.sync2[S_FMT +: 2]; // see RULE5 see RULE10
        dac_on = q.sync2[S_DAC]; // see RULE8 see RULE9
        d.strobe = 1'b0;
        // Both lines sampled on the rising bit clock edge
        d.lr = LNK.lrclk; // see RULE7 see RULE1
        lr_edge = LNK.lrclk != q.lr;
        if (lr_edge) begin
            // Word just ended belongs to the slot of the old level
            if (fmt == FMT_I2S) begin
                left_ch = !q.lr; // see RULE15
            end else begin
                left_ch = q.lr; // see RULE15
            end
            if (fmt[1]) begin
                word = sda_rj(q.shreg, fmt); // see RULE6
            end else begin
                word = sda_align(q.shreg, q.cnt); // see RULE3 see RULE6
            end
            if (dac_on) begin
                if (left_ch) begin
                    d.left = word;
                end else begin
                    // Right word closes the pair, so publish both
                    d.out_l = q.left;
                    d.out_r = word;
                    d.strobe = 1'b1;
                end
            end
        end
        // Shifting depends on the framing, the channel select edge and the bit count, never on standby
        if (fmt[1]) begin
            // Keep the last 24 bits; the edge marks the LSB boundary
            d.shreg = {q.shreg[SMP_W-2:0], LNK.sdata}; // see RULE6
        end else if (lr_edge) begin
            if (fmt == FMT_I2S) begin
                // MSB comes one bit clock after the edge
                d.shreg = '0;
                d.cnt = '0;
            end else begin
                d.shreg = {{(SMP_W-1){1'b0}}, LNK.sdata};
                d.cnt = CNT_W'(1);
            end
        end else if (q.cnt < CNT_W'(SMP_W)) begin
            // Bits beyond 24 are padding and ignored
            d.shreg = {q.shreg[SMP_W-2:0], LNK.sdata}; // see RULE3
            d.cnt = q.cnt + CNT_W'(1);
        end
        // Standby silences the outputs and drops the held word
        if (!dac_on) begin
            d.left = '0;
            d.out_l = '0;
            d.out_r = '0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge LNK.bclk) begin
        if (!RESET_N) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    assign LEFT_SAMPLE = q.out_l;
    assign RIGHT_SAMPLE = q.out_r;
    assign SAMPLE_STROBE = q.strobe;
    assign FORMAT = q.sync2[S_FMT +: 2];
    assign DAC_ACTIVE = q.sync2[S_DAC]; // see RULE8
    assign MIC_ACTIVE = q.sync2[S_MIC]; // see RULE12
    assign MONO_AMP_ON = q.sync2[S_MONO]; // see RULE14
    assign AMP_GAIN = q.sync2[S_GAIN +: 2]; // see RULE13
    assign MUTE_LEFT = q.sync2[S_MUTE_L];
    assign MUTE_RIGHT = q.sync2[S_MUTE_R];
endmodule

// *** design/sda_ctrl.sv ***
// Purpose: Controller end: link master and static line driver
// Assumes: Software reaches it over a plain strobe port
// Notes:   All link clocks are divided down from MCLK
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module sda_ctrl #(
    parameter int OS_HALF = sda_pkg::OS_HALF_DEF
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [sda_pkg::ADDR_W-1:0] ADDR,
    input wire logic [sda_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [sda_pkg::DATA_W-1:0] RDATA,
    // Link
    sda_link_if.ctrl LNK
);
    import sda_pkg::*;

    // Control word positions of the microphone, mono, gain and mute bits
    localparam int C_MIC = C_STAT + 1;
    localparam int C_MONO = C_STAT + 2;
    localparam int C_GAIN = C_STAT + 3;
    localparam int C_MUTE_L = C_STAT + 5;
    localparam int C_MUTE_R = C_STAT + 6;

    typedef struct packed {
        logic [PH_W-1:0] ph;
        logic [FRM_W-1:0] h;
        logic osclk;
        logic bclk;
        logic lr;
        logic sd;
        logic [CTRL_W-1:0] ctrl;
        logic [1:0] fmt;
        logic [SMP_W-1:0] left;
        logic [SMP_W-1:0] right;
        logic [SMP_W-1:0] shl;
        logic [SMP_W-1:0] shr;
        logic [CTRL_W-1:0] frames;
        logic [DATA_W-1:0] rdata;
    } sda_ctrl_t;

    sda_ctrl_t q;
    sda_ctrl_t d;
    logic [FRM_W-1:0] hn;
    logic [SMP_W-1:0] word;

    // ------------------------------------------------------------
    // Bit picker for one slot position
    // ------------------------------------------------------------
    function automatic logic sda_pick(input logic [SMP_W-1:0] w, input logic [1:0] f,
                                      input logic [4:0] wl, input logic [4:0] pos);
        logic [4:0] off;
        logic [4:0] len;
        logic [4:0] k;
        off = '0;
        len = (wl < LEN_MIN) ? LEN_MIN : ((wl > LEN_MAX) ? LEN_MAX : wl);
        unique case (f)
            FMT_I2S: off = OFF_I2S;
            FMT_LJ: off = '0;
            FMT_RJ16: begin
                off = OFF_RJ16;
                len = LEN_MIN;
            end
            FMT_RJ24: begin
                off = OFF_RJ24;
                len = LEN_MAX;
            end
        endcase
        k = pos - off;
        sda_pick = (pos >= off) && (k < len) ? w[5'(SMP_W - 1) - k] : 1'b0;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        hn = q.h + FRM_W'(1);
        word = '0;
        d.rdata = '0;
        if (RD) begin
            unique case (ADDR)
                REG_CTRL: d.rdata = DATA_W'(q.ctrl);
                REG_LEFT: d.rdata = DATA_W'(q.left);
                REG_RIGHT: d.rdata = DATA_W'(q.right);
                REG_STAT: d.rdata = DATA_W'(q.frames);
                default: d.rdata = '0;
            endcase
        end
        if (WR) begin
            unique case (ADDR)
                REG_CTRL: d.ctrl = WDATA[CTRL_W-1:0];
                REG_LEFT: d.left = WDATA[SMP_W-1:0];
                REG_RIGHT: d.right = WDATA[SMP_W-1:0];
                default: d.ctrl = q.ctrl;
            endcase
        end
        // Divider sets the sample rate; the default OS_HALF keeps it at or below the 48 kHz ceiling
        if (q.ph == PH_W'(OS_HALF - 1)) begin // see RULE4
            d.ph = '0;
            d.h = hn;
            // 512 half periods a frame: 256 oversample clocks per sample
            d.osclk = hn[0]; // see RULE2
            d.bclk = hn[2]; // see RULE1
            // Format moves only while stopped, on a bit clock rise, so it
            // never lands beside a channel select change
            if (hn[2:0] == 3'h4 && !q.ctrl[C_RUN]) begin
                d.fmt = q.ctrl[1:0]; // see RULE5
            end
            if (hn[2:0] == 3'h0) begin
                // Change on the falling bit clock, stable at the rise
                if (hn[FRM_W-1:3] == '0) begin
                    d.shl = q.left;
                    d.shr = q.right;
                    d.frames = q.frames + CTRL_W'(1);
                end
                word = hn[FRM_W-1] ? q.shr : ((hn[FRM_W-1:3] == '0) ? q.left : q.shl);
                d.lr = (q.fmt == FMT_I2S) ? hn[FRM_W-1] : !hn[FRM_W-1]; // see RULE7
                d.sd = q.ctrl[C_RUN] &&
                       sda_pick(word, q.fmt, q.ctrl[C_WLEN +: 5], hn[7:3]); // see RULE3
            end
        end else begin
            d.ph = q.ph + PH_W'(1);
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            q <= '0;
            q.ctrl <= CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign RDATA = q.rdata;
    assign LNK.osclk = q.osclk;
    assign LNK.bclk = q.bclk;
    assign LNK.lrclk = q.lr;
    assign LNK.sdata = q.sd;
    // Gain, mute and standby lines follow the control word
    assign LNK.ctl_val = {q.ctrl[C_MUTE_R], q.ctrl[C_MUTE_L], q.ctrl[C_MONO], q.ctrl[C_MIC],
                          q.ctrl[C_STAT], q.ctrl[C_GAIN +: 2], q.fmt}; // see RULE11
    assign LNK.ctl_oe_n = !q.ctrl[C_DRIVE];
endmodule

// *** tb/sda_assertions.sv ***
// Purpose: Link timing checks between controller and card
// Assumes: MCLK makes every link clock, so it samples them all
// Notes:   Half-period counters saturate, so idle gaps are not judged
`timescale 1ns/1ns
module sda_assertions #(
    parameter int OS_HALF = 6
) (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic lrclk,
    input wire logic sdata,
    input wire logic bclk,
    input wire logic osclk,
    input wire logic [sda_pkg::STAT_W-1:0] ctl_val,
    input wire logic ctl_oe_n,
    input wire logic [sda_pkg::STAT_W-1:0] ctl_line
);
    import sda_pkg::*;
    logic [7:0] os_cnt;
    logic [7:0] bc_cnt;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            os_cnt <= 8'hFF;
            bc_cnt <= 8'hFF;
        end else begin
            os_cnt <= $changed(osclk) ? 8'h00 : os_cnt + {7'h00, os_cnt != 8'hFF};
            bc_cnt <= $changed(bclk) ? 8'h00 : bc_cnt + {7'h00, bc_cnt != 8'hFF};
        end
    end
    property p_os_half;
        $changed(osclk) && os_cnt != 8'hFF |-> os_cnt == 8'(OS_HALF - 1);
    endproperty
    a_os_half: assert property (p_os_half) else $error("osclk half period wrong");
    property p_bclk_half;
        $changed(bclk) && bc_cnt != 8'hFF |-> bc_cnt == 8'(4 * OS_HALF - 1);
    endproperty
    a_bclk_half: assert property (p_bclk_half) else $error("bclk half period wrong");
    property p_bclk_osclk;
        $changed(bclk) |-> $changed(osclk);
    endproperty
    a_bclk_osclk: assert property (p_bclk_osclk) else $error("bclk off osclk edge");
    property p_sdata_fall;
        $changed(sdata) |-> $fell(bclk);
    endproperty
    a_sdata_fall: assert property (p_sdata_fall) else $error("sdata moved off bclk fall");
    property p_lrclk_fall;
        $changed(lrclk) |-> $fell(bclk);
    endproperty
    a_lrclk_fall: assert property (p_lrclk_fall) else $error("lrclk moved off bclk fall");
    property p_fmt_frozen;
        $changed(ctl_line[S_FMT+:2]) |-> $stable(lrclk) ##1 $stable(lrclk);
    endproperty
    a_fmt_frozen: assert property (p_fmt_frozen) else $error("format moved mid frame");
    property p_release_low;
        ctl_oe_n |-> ctl_line == '0;
    endproperty
    a_release_low: assert property (p_release_low) else $error("released line not low");
    property p_drive;
        !ctl_oe_n |-> ctl_line == ctl_val;
    endproperty
    a_drive: assert property (p_drive) else $error("driven line mismatch");
endmodule

// *** tb/stereo_dac_serial_audio_input_test.sv ***
// Purpose: Self-checking bench, controller and card joined by the link
// Assumes: OS_HALF of 2 keeps a frame at 1024 MCLK cycles
// Notes:   Card reset moves on bclk fall to avoid racing its edge
`timescale 1ns/1ns
module stereo_dac_serial_audio_input_test;
    import sda_pkg::*;
    localparam int OSH = 2;
    localparam int FRAME = 512 * OSH;
    localparam logic [1:0] TF [6] = '{FMT_I2S, FMT_LJ, FMT_RJ16, FMT_RJ24, FMT_I2S, FMT_LJ};
    localparam int TW [6] = '{24, 16, 24, 24, 20, 31};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic card_rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [SMP_W-1:0] left;
    logic [SMP_W-1:0] right;
    logic stb;
    logic [1:0] fmt;
    logic [1:0] gain;
    logic dac;
    logic mic;
    logic mono;
    logic mute_l;
    logic mute_r;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    sda_link_if lnk ();
    sda_ctrl #(.OS_HALF(OSH)) sda_ctrl_inst (.MCLK(mclk), .RESET_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LNK(lnk));
    sda_card sda_card_inst (.LNK(lnk), .RESET_N(card_rst_n), .LEFT_SAMPLE(left),
        .RIGHT_SAMPLE(right), .SAMPLE_STROBE(stb), .FORMAT(fmt), .DAC_ACTIVE(dac),
        .MIC_ACTIVE(mic), .MONO_AMP_ON(mono), .AMP_GAIN(gain), .MUTE_LEFT(mute_l),
        .MUTE_RIGHT(mute_r));
    sda_assertions #(.OS_HALF(OSH)) sda_assertions_inst (.MCLK(mclk), .RESET_N(rst_n),
        .lrclk(lnk.lrclk), .sdata(lnk.sdata), .bclk(lnk.bclk), .osclk(lnk.osclk),
        .ctl_val(lnk.ctl_val), .ctl_oe_n(lnk.ctl_oe_n), .ctl_line(lnk.ctl_line));
    initial begin
        forever #4 mclk = ~mclk;
    end
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Counts MCLK cycles up to the next strobe rise
    task automatic wait_stb(output int n);
        n = 0;
        while (stb === 1'b1 && n < 4000) begin
            @(negedge mclk);
            n++;
        end
        while (stb !== 1'b1 && n < 4000) begin
            @(negedge mclk);
            n++;
        end
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        int n;
        logic [2:0] iv;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] ctl;
        logic [31:0] f0;
        int w;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rd_reg(REG_CTRL, d);
        chk("ctrl reset", 32'h00000060, d);
        rd_reg(4'hF, d);
        chk("unmapped", 32'h00000000, d);
        wr_reg(REG_CTRL, 32'h00008000);
        repeat (4) @(negedge lnk.bclk);
        card_rst_n <= 1'b1;
        n = 0;
        repeat (3 * FRAME) @(negedge mclk) n += int'(stb === 1'b1);
        chk("released", 32'h0, {fmt, dac, mic, mono, gain, mute_l, mute_r});
        chk("standby strobes", 32'h0, n);
        chk("standby left", 32'h0, left);
        for (int i = 0; i < 6; i++) begin
            iv = 3'(i);
            ctl = {16'h0, 2'h3, iv[1], iv[0], iv[1:0], ~iv[0], iv[0], 1'b1, 5'(TW[i]), TF[i]};
            if (i > 0) begin
                wr_reg(REG_CTRL, ctl);
                repeat (FRAME) @(posedge mclk);
                chk("format held", TF[i-1], fmt);
            end
            wr_reg(REG_CTRL, ctl & 32'h7FFF);
            // Format is latched on a bit clock rise, so give it one bit cell
            repeat (8 * OSH) @(posedge mclk);
            wr_reg(REG_LEFT, 32'h8F3C5B ^ 32'(i));
            wr_reg(REG_RIGHT, 32'h71A2C9 ^ 32'(i));
            wr_reg(REG_CTRL, ctl);
            wait_stb(n);
            wait_stb(n);
            wait_stb(n);
            chk("frame cycles", FRAME, n);
            w = TF[i] == FMT_RJ16 ? 16 : (TF[i] == FMT_RJ24 || TW[i] > 24) ? 24 : TW[i];
            m = 32'hFFFFFF & ~((32'h1 << (24 - w)) - 32'h1);
            chk("left", (32'h8F3C5B ^ 32'(i)) & m, left);
            chk("right", (32'h71A2C9 ^ 32'(i)) & m, right);
            chk("static", {TF[i], 1'b1, iv[0], ~iv[0], iv[1:0], iv[0], iv[1]},
                {fmt, dac, mic, mono, gain, mute_l, mute_r});
            rd_reg(REG_LEFT, d);
            chk("left reg", 32'h8F3C5B ^ 32'(i), d);
            rd_reg(REG_RIGHT, d);
            chk("right reg", 32'h71A2C9 ^ 32'(i), d);
        end
        // Two reads exactly one frame apart see exactly one frame start
        rd_reg(REG_STAT, f0);
        repeat (FRAME - 2) @(posedge mclk);
        rd_reg(REG_STAT, d);
        chk("frame count", 32'h1, d - f0);
        report_and_stop();
    end
endmodule
